// file: rtl/swire_pkg.sv
// Purpose: types of the single-wire thermometer slave
// Assumes: nothing
// Notes:   constants live in swire_regs.svh
package swire_pkg;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_PRES_WAIT = 3'b001,
    ST_PRES_LOW  = 3'b010,
    ST_CMD       = 3'b011,
    ST_WDATA     = 3'b100,
    ST_RDATA     = 3'b101,
    ST_DONE      = 3'b110
  } link_state_t;
endpackage

// file: rtl/swire_regs.svh
// Purpose: timing constants and opcodes of the single-wire thermometer slave
// Assumes: 25 MHz reference clock, 1 us tick from a divider
// Notes:   all counts are in 1 us ticks unless named _CYC
`ifndef SWIRE_REGS_SVH
`define SWIRE_REGS_SVH

// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_MHZ          25
`define TICK_DIV_CYC     (`CLK_MHZ)
// ----------------------------------------
// bus times in microseconds
// ----------------------------------------
`define T_RESET_US       12'd480
`define T_PRES_WAIT_US   12'd30
`define T_PRES_LOW_US    12'd120
`define T_SAMPLE_US      12'd30
`define T_RDV_US         12'd14
`define T_PRES_MIN_US    12'd60
`define T_PRES_MAX_US    12'd240
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_READ_TEMP     8'haa
`define OP_START_CONV    8'hee
`define OP_STOP_CONV     8'h22
`define OP_WRITE_HIGH    8'h01
`define OP_WRITE_LOW     8'h02
`define OP_READ_HIGH     8'ha1
`define OP_READ_LOW      8'ha2
`define OP_WRITE_STATUS  8'h0c
`define OP_READ_STATUS   8'hac
`define OP_READ_COUNTER  8'ha0
`define OP_LOAD_COUNTER  8'h41
// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define BYTE_BITS        4'd8
`define COUNT_BITS       4'd9
`define SINGLE_CONV_BIT  0
`define STATUS_DONE_BIT  7
`define STATUS_FIXED_BIT 6
`define STATUS_BUSY_BIT  5
`define STATUS_RST_VAL   8'h40

`endif

// file: rtl/swire_thermo_slave.sv
// Purpose: slave end of the single-wire link of a thermometer/thermostat
// Assumes: only slave on the line; master keeps its own slot timing
// Notes:   temperature and slope accumulator come in as ports
// Operation
// - read-temperature opcode returns the latest 8-bit temperature
// - write-trip opcodes take one byte into high or low trip register
// - read-trip opcodes return the chosen trip register byte
// - write-status opcode takes one byte into status/configuration
// - read-status opcode returns the status/configuration byte
// - read-counter opcode shifts out the 9-bit counter over nine slots
// - load-counter opcode copies slope accumulator into counter, no data
// - master starts all signalling; device drives only presence and read-slot zeros
// - after reset ends wait 15-60 us, then drive low 60-240 us
// - each slot carries exactly one bit
// - device samples 15-60 us after slot falling edge
// - device sends zero by holding low, releases before slot end
// - read data valid only 15 us after slot falling edge
// - all opcodes and data go least significant bit first
// - line low over 480 us resets the link anywhere
// - start-conversion: one or continuous per mode; stop ends continuous
`timescale 1ns/10ps
`default_nettype none
`include "swire_regs.svh"
module swire_thermo_slave #(
  parameter int CLK_MHZ = `CLK_MHZ
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_line,
  input  wire logic [7:0] i_temperature,
  input  wire logic [8:0] i_slope_acc,
  input  wire logic [7:0] i_status_hw,
  output logic            o_line_oe,
  output logic            o_line,
  output logic            o_conv_run,
  output logic            o_conv_start,
  output logic [7:0]      o_high_trip,
  output logic [7:0]      o_low_trip,
  output logic [7:0]      o_status
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                      sync1;
    logic                      sync2;
    logic                      prev;
    swire_pkg::link_state_t    state;
    logic [11:0]               low_us;
    logic [11:0]               slot_us;
    logic                      in_slot;
    logic                      sampled;
    logic [7:0]                opcode;
    logic [3:0]                nbits;
    logic [8:0]                shreg;
    logic                      drive;
    logic [7:0]                high_trip_register;
    logic [7:0]                low_trip_register;
    logic [7:0]                status;
    logic [8:0]                counter;
    logic                      conv_run;
    logic                      conv_start;
  } slave_state_t;
  slave_state_t st_reg;
  slave_state_t st_next;
  logic         tick;
  logic         line_s;
  logic         fall;
  logic         rise;
  swire_us_tick #(.DIV(CLK_MHZ)) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );
  assign line_s = st_reg.sync2;
  assign fall   = st_reg.prev & ~line_s;
  assign rise   = ~st_reg.prev & line_s;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sync1      = i_line;
    st_next.sync2      = st_reg.sync1;
    st_next.prev       = st_reg.sync2;
    st_next.conv_start = 1'b0;
    // long-low counter runs in every state
    if (line_s) begin
      st_next.low_us = 12'h000;
    end else if (tick && st_reg.low_us != 12'hfff) begin
      st_next.low_us = st_reg.low_us + 12'h001;
    end
    if (tick && st_reg.slot_us != 12'hfff) begin
      st_next.slot_us = st_reg.slot_us + 12'h001;
    end
    // slot opens on a falling edge; one bit per slot
    if (fall && st_reg.state != swire_pkg::ST_PRES_LOW) begin
      st_next.slot_us = 12'h000;
      st_next.in_slot = 1'b1;
      st_next.sampled = 1'b0;
    end
    case (st_reg.state)
      swire_pkg::ST_IDLE: begin
        st_next.drive = 1'b0;
      end
      swire_pkg::ST_PRES_WAIT: begin
        if (st_reg.slot_us >= `T_PRES_WAIT_US) begin
          st_next.state   = swire_pkg::ST_PRES_LOW;
          st_next.drive   = 1'b1;
          st_next.slot_us = 12'h000;
        end
      end
      swire_pkg::ST_PRES_LOW: begin
        if (st_reg.slot_us >= `T_PRES_LOW_US) begin
          st_next.drive   = 1'b0;
          st_next.state   = swire_pkg::ST_CMD;
          st_next.in_slot = 1'b0;
          st_next.nbits   = 4'h0;
        end
      end
      swire_pkg::ST_CMD, swire_pkg::ST_WDATA: begin
        // sample mid-window, lsb first
        if (st_reg.in_slot && !st_reg.sampled && st_reg.slot_us >= `T_SAMPLE_US) begin
          st_next.sampled = 1'b1;
          st_next.shreg   = {line_s, st_reg.shreg[8:1]};
          st_next.nbits   = st_reg.nbits + 4'h1;
          if (st_reg.nbits == `BYTE_BITS - 4'h1) begin
            st_next.nbits = 4'h0;
            if (st_reg.state == swire_pkg::ST_WDATA) begin
              st_next.state = swire_pkg::ST_DONE;
              case (st_reg.opcode)
                `OP_WRITE_HIGH: st_next.high_trip_register = {line_s, st_reg.shreg[8:2]};
                `OP_WRITE_LOW:  st_next.low_trip_register  = {line_s, st_reg.shreg[8:2]};
                default:        st_next.status = {line_s, st_reg.shreg[8:2]};
              endcase
            end else begin
              st_next.opcode = {line_s, st_reg.shreg[8:2]};
              st_next.state  = swire_pkg::ST_DONE;
              case ({line_s, st_reg.shreg[8:2]})
                `OP_WRITE_HIGH, `OP_WRITE_LOW, `OP_WRITE_STATUS: begin
                  st_next.state = swire_pkg::ST_WDATA;
                end
                `OP_READ_TEMP: begin
                  st_next.shreg = {1'b1, i_temperature};
                  st_next.state = swire_pkg::ST_RDATA;
                end
                `OP_READ_HIGH: begin
                  st_next.shreg = {1'b1, st_reg.high_trip_register};
                  st_next.state = swire_pkg::ST_RDATA;
                end
                `OP_READ_LOW: begin
                  st_next.shreg = {1'b1, st_reg.low_trip_register};
                  st_next.state = swire_pkg::ST_RDATA;
                end
                `OP_READ_STATUS: begin
                  st_next.shreg = {1'b1, st_reg.status};
                  st_next.state = swire_pkg::ST_RDATA;
                end
                `OP_READ_COUNTER: begin
                  st_next.shreg = st_reg.counter;
                  st_next.state = swire_pkg::ST_RDATA;
                end
                `OP_LOAD_COUNTER: begin
                  st_next.counter = i_slope_acc;
                end
                `OP_START_CONV: begin
                  st_next.conv_start = 1'b1;
                  st_next.conv_run   = ~st_reg.status[`SINGLE_CONV_BIT];
                end
                `OP_STOP_CONV: begin
                  st_next.conv_run = 1'b0;
                end
                default: begin
                  st_next.state = swire_pkg::ST_DONE;
                end
              endcase
            end
          end
        end
      end
      swire_pkg::ST_RDATA: begin
        // drive a zero from the falling edge, release after the valid time
        if (fall) begin
          st_next.drive = ~st_reg.shreg[0];
        end
        if (st_reg.in_slot && !st_reg.sampled && st_reg.slot_us >= `T_RDV_US) begin
          st_next.drive   = 1'b0;
          st_next.sampled = 1'b1;
          st_next.shreg   = {1'b1, st_reg.shreg[8:1]};
          st_next.nbits   = st_reg.nbits + 4'h1;
          if (st_reg.nbits == ((st_reg.opcode == `OP_READ_COUNTER) ?
                               `COUNT_BITS - 4'h1 : `BYTE_BITS - 4'h1)) begin
            st_next.state = swire_pkg::ST_DONE;
          end
        end
      end
      swire_pkg::ST_DONE: begin
        st_next.drive = 1'b0;
      end
      default: begin
        st_next.state = swire_pkg::ST_IDLE;
        st_next.drive = 1'b0;
      end
    endcase
    // reset pulse ends: start presence wait
    if (rise && st_reg.low_us >= `T_RESET_US) begin
      st_next.state   = swire_pkg::ST_PRES_WAIT;
      st_next.slot_us = 12'h000;
      st_next.drive   = 1'b0;
      st_next.in_slot = 1'b0;
      st_next.nbits   = 4'h0;
    end else if (!line_s && st_reg.low_us >= `T_RESET_US && !st_reg.drive) begin
      st_next.state = swire_pkg::ST_IDLE;
      st_next.drive = 1'b0;
    end
    // hardware-owned status bits; a status write cannot fake done or busy
    st_next.status[`STATUS_DONE_BIT]  = i_status_hw[`STATUS_DONE_BIT];
    st_next.status[`STATUS_FIXED_BIT] = 1'b1;
    st_next.status[`STATUS_BUSY_BIT]  = i_status_hw[`STATUS_BUSY_BIT];
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg        <= '0;
      st_reg.sync1  <= 1'b1;
      st_reg.sync2  <= 1'b1;
      st_reg.prev   <= 1'b1;
      st_reg.state  <= swire_pkg::ST_IDLE;
      st_reg.status <= `STATUS_RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_line_oe    = st_reg.drive;
  assign o_line       = 1'b0;
  assign o_conv_run   = st_reg.conv_run;
  assign o_conv_start = st_reg.conv_start;
  assign o_high_trip  = st_reg.high_trip_register;
  assign o_low_trip   = st_reg.low_trip_register;
  assign o_status     = st_reg.status;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  int unsigned pres_cnt;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pres_cnt <= 0;
    end else begin
      pres_cnt <= (st_reg.state == swire_pkg::ST_PRES_LOW && st_reg.drive) ? pres_cnt + 1 : 0;
    end
  end
  sequence s_reset_end;
    rise && st_reg.low_us >= `T_RESET_US;
  endsequence
  chk_pres_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_reset_end |-> !st_next.drive [*8])
    else $error("presence started too early");
  chk_pres_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pres_cnt <= `T_PRES_MAX_US * CLK_MHZ)
    else $error("presence pulse too long");
  chk_pres_min: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.state == swire_pkg::ST_PRES_LOW && st_next.state == swire_pkg::ST_CMD |->
      pres_cnt >= `T_PRES_MIN_US * CLK_MHZ)
    else $error("presence pulse too short");
  chk_drive_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.drive |-> (st_reg.state == swire_pkg::ST_PRES_LOW ||
                      st_reg.state == swire_pkg::ST_RDATA))
    else $error("line driven outside presence or read");
  chk_read_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.drive && st_reg.state == swire_pkg::ST_RDATA |-> st_reg.slot_us <= `T_RDV_US)
    else $error("read zero held past valid time");
  chk_load_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $changed(st_reg.counter) |-> st_reg.opcode == `OP_LOAD_COUNTER &&
      st_reg.state == swire_pkg::ST_DONE)
    else $error("counter changed outside load");
  chk_done_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.state == swire_pkg::ST_DONE && !rise |=> !st_reg.drive)
    else $error("device drove after transaction end");
  chk_start_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.conv_start |-> st_reg.conv_run == ~st_reg.status[`SINGLE_CONV_BIT])
    else $error("conversion mode mismatch");
  chk_stop_conv: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.state == swire_pkg::ST_DONE && st_reg.opcode == `OP_STOP_CONV |-> !st_reg.conv_run)
    else $error("conversion still running after stop");
  chk_long_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !line_s && st_reg.low_us >= `T_RESET_US && !st_reg.drive |=>
      st_reg.state == swire_pkg::ST_IDLE || st_reg.state == swire_pkg::ST_PRES_WAIT)
    else $error("long low did not reset link");
endmodule
`default_nettype wire

// file: rtl/swire_us_tick.sv
// Purpose: one-cycle enable every microsecond
// Assumes: DIV cycles of i_ref_clk per microsecond
// Notes:   state is one packed struct
`timescale 1ns/10ps
`default_nettype none
module swire_us_tick #(
  parameter int DIV = 25
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tick_state_t;

  tick_state_t st_reg;
  tick_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 8'(DIV - 1)) begin
      st_next.cnt  = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;
endmodule
`default_nettype wire

// file: verification/swire_master_model.sv
// Purpose: bus master model driving the single-wire line of the slave
// Assumes: US_CYC clock cycles make one microsecond; pull-up on the line
// Notes:   line is the wired-and of master and device pull-downs
`timescale 1ns/10ps
`default_nettype none
module swire_master_model #(
  parameter int US_CYC = 2
) (
  input  wire logic i_ref_clk,
  input  wire logic i_line_oe,
  input  wire logic i_line_val,
  output logic      o_line
);
  // ----------------------------------------
  // wire level
  // ----------------------------------------
  logic master_low;
  int   late_release;
  // pull-up wins whenever nobody pulls down
  assign o_line = ~master_low & (i_line_oe ? i_line_val : 1'b1);
  initial begin
    master_low   = 1'b0;
    late_release = 0;
  end
  // ----------------------------------------
  // slot tasks, all moves on the falling edge
  // ----------------------------------------
  task automatic wait_us(input int n);
    repeat (n * US_CYC) @(negedge i_ref_clk);
  endtask
  // reset pulse, then time the device answer in microseconds
  task automatic reset_pulse(output int t_wait, output int t_low);
    t_wait = 0;
    t_low  = 0;
    master_low = 1'b1;
    wait_us(500);
    master_low = 1'b0;
    for (int i = 0; i < 200; i++) begin
      wait_us(1);
      if (o_line === 1'b0) t_low++;
      else if (t_low == 0) t_wait++;
    end
  endtask
  // early release for a one, whole slot low for a zero
  task automatic write_bit(input logic b);
    master_low = 1'b1;
    wait_us(b ? 3 : 70);
    master_low = 1'b0;
    wait_us(b ? 70 : 3);
  endtask
  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask
  // short opening, sample late inside the valid window
  task automatic read_bits(input int n, output logic [8:0] v);
    v = 9'h000;
    for (int i = 0; i < n; i++) begin
      master_low = 1'b1;
      wait_us(2);
      master_low = 1'b0;
      wait_us(10);
      v[i] = o_line;
      wait_us(58);
      if (o_line !== 1'b1) late_release++;
      wait_us(3);
    end
  endtask
endmodule
`default_nettype wire

// file: verification/tb_swire_thermo_slave.sv
// Purpose: self-checking bench of the single-wire thermometer slave
// Assumes: divider shortened to 2 cycles per microsecond to keep runs short
// Notes:   scenarios run whole transactions through the master model, except sc_refuse, which cuts one off after four data bits
`timescale 1ns/10ps
`default_nettype none
module tb_swire_thermo_slave;
  localparam int US_CYC = 2;
  logic       ref_clk;
  logic       rst;
  logic       line;
  logic [7:0] temperature;
  logic [8:0] slope_acc;
  logic [7:0] status_hw;
  logic       line_oe;
  logic       line_val;
  logic       conv_run;
  logic       conv_start;
  logic [7:0] high_trip;
  logic [7:0] low_trip;
  logic [7:0] status;
  int         failures;
  int         checks;
  int         conv_starts = 0;
  swire_thermo_slave #(.CLK_MHZ(US_CYC)) u_swire_thermo_slave (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_line(line), .i_temperature(temperature),
    .i_slope_acc(slope_acc), .i_status_hw(status_hw), .o_line_oe(line_oe),
    .o_line(line_val), .o_conv_run(conv_run), .o_conv_start(conv_start),
    .o_high_trip(high_trip), .o_low_trip(low_trip), .o_status(status));
  swire_master_model #(.US_CYC(US_CYC)) u_swire_master_model (
    .i_ref_clk(ref_clk), .i_line_oe(line_oe), .i_line_val(line_val), .o_line(line));
  // ----------------------------------------
  // clock, counters, compare tasks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (conv_start === 1'b1) conv_starts <= conv_starts + 1;
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_rng(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("wrong value at %0t: %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // transaction helpers
  // ----------------------------------------
  task automatic begin_txn();
    int tw;
    int tl;
    u_swire_master_model.reset_pulse(tw, tl);
    check_rng(tw, 15, 34, "presence wait");
    check_rng(tl, 118, 123, "presence length");
  endtask
  task automatic wr_cmd(input logic [7:0] op, input logic [7:0] d, input bit has_data);
    begin_txn();
    u_swire_master_model.write_byte(op);
    if (has_data) u_swire_master_model.write_byte(d);
  endtask
  task automatic rd_cmd(input logic [7:0] op, input int n, input logic [8:0] exp);
    logic [8:0] v;
    begin_txn();
    u_swire_master_model.write_byte(op);
    u_swire_master_model.read_bits(n, v);
    check_val(v, exp, "read data");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_trip();
    wr_cmd(8'h01, 8'h28, 1'b1);
    check_val({1'b0, high_trip}, 9'h028, "high trip");
    wr_cmd(8'h02, 8'h0a, 1'b1);
    check_val({1'b0, low_trip}, 9'h00a, "low trip");
    rd_cmd(8'ha1, 8, 9'h028);
    rd_cmd(8'ha2, 8, 9'h00a);
  endtask
  task automatic sc_temp();
    temperature = 8'h93;
    rd_cmd(8'haa, 8, 9'h093);
  endtask
  task automatic sc_status();
    // hardware-owned bits 7, 6, 5 must not follow the written byte
    wr_cmd(8'h0c, 8'hba, 1'b1);
    check_val({1'b0, status}, 9'h05a, "status");
    status_hw = 8'ha0;
    rd_cmd(8'hac, 8, 9'h0fa);
  endtask
  task automatic sc_conv();
    int n0;
    n0 = conv_starts;
    wr_cmd(8'hee, 8'h00, 1'b0);
    check_val({8'h00, conv_run}, 9'h001, "continuous run");
    wr_cmd(8'h22, 8'h00, 1'b0);
    check_val({8'h00, conv_run}, 9'h000, "stopped");
    wr_cmd(8'hee, 8'h00, 1'b0);
    check_val({8'h00, conv_run}, 9'h001, "restarted");
    // one-shot start must drop a running continuous conversion
    wr_cmd(8'h0c, 8'h01, 1'b1);
    wr_cmd(8'hee, 8'h00, 1'b0);
    check_val({8'h00, conv_run}, 9'h000, "one-shot run");
    check_rng(conv_starts - n0, 3, 3, "start pulses");
  endtask
  task automatic sc_counter();
    slope_acc = 9'h1a5;
    wr_cmd(8'h41, 8'h00, 1'b0);
    slope_acc = 9'h05a;
    rd_cmd(8'ha0, 9, 9'h1a5);
  endtask
  task automatic sc_refuse();
    begin_txn();
    u_swire_master_model.write_byte(8'h01);
    u_swire_master_model.write_byte(8'h3c);
    u_swire_master_model.write_byte(8'hc3);
    check_val({1'b0, high_trip}, 9'h03c, "extra byte");
    rd_cmd(8'h55, 8, 9'h0ff);
    begin_txn();
    u_swire_master_model.write_byte(8'h02);
    for (int i = 0; i < 4; i++) u_swire_master_model.write_bit(1'b0);
    rd_cmd(8'ha2, 8, 9'h00a);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    failures    = 0;
    checks      = 0;
    rst         = 1'b1;
    temperature = 8'h5c;
    slope_acc   = 9'h000;
    status_hw   = 8'h00;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check_val({1'b0, status}, 9'h040, "status after reset");
    check_val({1'b0, high_trip}, 9'h000, "trip after reset");
    sc_trip();
    sc_temp();
    sc_status();
    sc_conv();
    sc_counter();
    sc_refuse();
    check_rng(u_swire_master_model.late_release, 0, 0, "late release");
    report_and_stop();
  end
  // about 31 ms of bus time is 62000 cycles at 2 per microsecond; limit adds margin
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
